// File: src/smrr_pkg.sv
/*
 * Constants for the supply monitor and reference register bank: offsets,
 * field positions, reset values, codes and timing counts.
 * Assumes a 40 MHz system clock and 8-bit byte addresses on a 32-bit register port.
 */
package smrr_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS    = 25000;
	localparam int unsigned SYNC_NS          = 75;
	localparam int unsigned SYNC_CYCLES      = (SYNC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CLK_START_NS     = 200;
	localparam int unsigned CLK_START_CYCLES =
		(CLK_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CLK_STOP_NS      = 100;
	localparam int unsigned CLK_STOP_CYCLES  =
		(CLK_STOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_LOOP_SYNC = 8'h30;
	localparam logic [7:0] OFS_MON_CTRL  = 8'h34;
	localparam logic [7:0] OFS_REF_CTRL  = 8'h40;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h60;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h64;
	localparam logic [7:0] OFS_SYNC_STAT = 8'h68;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned REFRESH_BIT   = 7;
	localparam int unsigned MON_LEVEL_LSB = 16;
	localparam int unsigned MON_PSEL_LSB  = 12;
	localparam int unsigned MON_CEN_BIT   = 9;
	localparam int unsigned MON_MODE_BIT  = 8;
	localparam int unsigned MON_STBY_BIT  = 6;
	localparam int unsigned MON_ACT_LSB   = 3;
	localparam int unsigned MON_THRESHOLD_HYSTERESIS_BIT  = 2;
	localparam int unsigned MON_EN_BIT    = 1;
	localparam int unsigned REF_TRIM_LSB  = 16;
	localparam int unsigned REF_BG_BIT    = 2;
	localparam int unsigned REF_TS_BIT    = 1;
	localparam int unsigned IRQ_LOOP_RDY  = 0;
	localparam int unsigned IRQ_SYNC_DONE = 1;
	localparam int unsigned IRQ_UNDERVOLT = 2;

	// ------------------------------------------------------------
	// Codes and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] ACT_NONE  = 2'h0;
	localparam logic [1:0] ACT_RESET = 2'h1;
	localparam logic [1:0] ACT_IRQ   = 2'h2;
	localparam logic [3:0] PSEL_RST  = 4'h0;
	localparam logic [2:0] MASK_RST  = 3'h0;

	typedef enum logic [3:0] {
		CLK_OFF   = 4'b0001,
		CLK_START = 4'b0010,
		CLK_ON    = 4'b0100,
		CLK_STOP  = 4'b1000
	} smrr_clk_e;

endpackage

// File: src/smrr_prescaler.sv
/*
 * Sampling prescaler: counts edges of the slow oscillator and emits one
 * system-clock tick every 2^(code+1) oscillator periods.
 * Assumes the oscillator input is asynchronous to the system clock.
 */
`timescale 1ns/1ps
module smrr_prescaler (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Control
	input  wire logic       i_run,
	input  wire logic [3:0] i_psel,
	// Slow oscillator
	input  wire logic       i_osc_1k,
	// Sample tick
	output logic            o_tick
);
	import smrr_pkg::*;

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        s3;
		logic [15:0] cnt;
		logic        tick;
	} smrr_pre_s;

	smrr_pre_s state_q;
	smrr_pre_s state_d;
	logic      edge_seen;
	logic [15:0] mask;

	function automatic logic [15:0] div_mask(input logic [3:0] c);
		div_mask = 16'((17'h1 << (5'(c) + 5'h1)) - 17'h1);
	endfunction

	assign edge_seen = state_q.s2 & ~state_q.s3;
	assign mask      = div_mask(i_psel);

	always_comb begin
		state_d      = state_q;
		state_d.s1   = i_osc_1k;
		state_d.s2   = state_q.s1;
		state_d.s3   = state_q.s2;
		state_d.tick = 1'b0;
		if (!i_run) begin
			state_d.cnt = 16'h0000;
		end else if (edge_seen) begin
			state_d.cnt  = state_q.cnt + 16'h0001;
			state_d.tick = (state_q.cnt & mask) == mask;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_tick = state_q.tick;

	tick_cause_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_tick |-> $past(i_run && edge_seen && ((state_q.cnt & mask) == mask)))
		else $error("prescaler tick without a completed division");

endmodule

// File: src/smrr_top.sv
/*
 * Register bank for the loop refresh request, the supply monitor control
 * and the voltage reference control, with interrupt status and mask.
 * Assumes a single-cycle register port on the system clock, an analog
 * comparator output and slow oscillator that are asynchronous, and
 * nonvolatile values valid at reset release.
 */
`timescale 1ns/1ps
// Operation
// - Writing one to bit 7 in closed loop requests a loop value refresh.
// - Reserved bits of all three registers read back as zero.
// - Level, action, hysteresis and enable load from nonvolatile row at startup.
// - Prescaler code divides the sampling clock by two to code plus one.
// - The prescaler counts the slow oscillator's 1kHz output.
// - Clock-enable readback is one while running stable or still stopping.
// - Writing clock-enable zero stops the sampling clock, one starts it.
// - Mode bit selects continuous or prescaled sampling operation.
// - Keep-in-standby zero disables the monitor during standby.
// - Action field selects nothing, reset or interrupt on under-voltage.
// - Hysteresis bit applies hysteresis to the threshold comparison.
// - Enable bit turns the supply monitor on or off.
// - Bandgap trim loads from the nonvolatile calibration row at startup.
// - Bandgap-to-ADC bit routes the bandgap output to an ADC channel.
// - Temperature-sensor bit enables the sensor and routes it to the ADC.
module smrr_top (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// Frequency locked loop
	input  wire logic        i_loop_closed,
	input  wire logic        i_loop_ready,
	output logic             o_value_refresh_req,
	// Nonvolatile startup values
	input  wire logic [5:0]  i_nv_level,
	input  wire logic [1:0]  i_nv_action,
	input  wire logic        i_nv_threshold_hysteresis,
	input  wire logic        i_nv_enable,
	input  wire logic [10:0] i_nv_trim,
	// Supply monitor
	input  wire logic        i_osc_1k,
	input  wire logic        i_standby,
	input  wire logic        i_supply_low,
	output logic             o_mon_enable,
	output logic      [5:0]  o_mon_level,
	output logic             o_mon_threshold_hysteresis,
	output logic             o_mon_sampling,
	output logic             o_mon_sample_strobe,
	output logic             o_mon_reset_req,
	// Voltage reference
	output logic      [10:0] o_bg_trim,
	output logic             o_bg_to_adc,
	output logic             o_temp_sensor_on,
	// Interrupt
	output logic             o_irq
);
	import smrr_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] rdata;
		logic        refresh;
		logic        loaded;
		logic [5:0]  lvl;
		logic [3:0]  psel;
		logic        sample_clock_on;
		logic        mode;
		logic        stby;
		logic [1:0]  act;
		logic        threshold_hysteresis;
		logic        en;
		logic [10:0] trim;
		logic        bg;
		logic        ts;
		logic [2:0]  stat;
		logic [2:0]  mask;
		logic        busy;
		logic [1:0]  sync_cnt;
		logic [5:0]  a_lvl;
		logic [3:0]  a_psel;
		logic        a_cen;
		logic        a_mode;
		logic        a_stby;
		logic [1:0]  a_act;
		logic        a_threshold_hysteresis;
		logic        a_en;
		smrr_clk_e   clk;
		logic [3:0]  clk_cnt;
		logic        low_s1;
		logic        low_s2;
		logic        ready_prev;
		logic        mon_en;
		logic        strobe;
		logic        rst_req;
		logic        irq;
	} smrr_state_s;

	smrr_state_s state_q;
	smrr_state_s state_d;
	logic        tick;
	logic        eff_en;
	logic        evaluate;
	logic        below;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// ------------------------------------------------------------
	// Sampling prescaler
	// ------------------------------------------------------------
	smrr_prescaler u_prescaler (
		.i_clk    (i_clk),
		.i_rstn   (i_rstn),
		.i_run    (state_q.clk != CLK_OFF),
		.i_psel   (state_q.a_psel),
		.i_osc_1k (i_osc_1k),
		.o_tick   (tick)
	);

	// In sampling mode the comparator is only trusted when the sampling clock ticks, so a
	// sampling monitor with a stopped clock never raises an action.
	assign eff_en   = state_q.a_en & ~(i_standby & ~state_q.a_stby);
	assign evaluate = ~state_q.a_mode | (tick & (state_q.clk == CLK_ON));
	assign below    = state_q.low_s2 & eff_en & evaluate;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [2:0] set;
		logic [2:0] clr;
		set                = 3'h0;
		clr                = 3'h0;
		state_d            = state_q;
		state_d.rdata      = 32'h0000_0000;
		state_d.refresh    = 1'b0;
		state_d.low_s1     = i_supply_low;
		state_d.low_s2     = state_q.low_s1;
		state_d.ready_prev = i_loop_ready;

		if (!state_q.loaded) begin
			state_d.loaded = 1'b1;
			state_d.lvl    = i_nv_level;
			state_d.act    = i_nv_action;
			state_d.threshold_hysteresis   = i_nv_threshold_hysteresis;
			state_d.en     = i_nv_enable;
			state_d.a_lvl  = i_nv_level;
			state_d.a_act  = i_nv_action;
			state_d.a_threshold_hysteresis = i_nv_threshold_hysteresis;
			state_d.a_en   = i_nv_enable;
			state_d.trim   = i_nv_trim;
		end else if (i_wr) begin
			if (hit(i_addr, OFS_LOOP_SYNC)) begin
				state_d.refresh = i_wdata[REFRESH_BIT] & i_loop_closed;
			end
			if (hit(i_addr, OFS_MON_CTRL) && !state_q.busy) begin
				state_d.lvl      = i_wdata[MON_LEVEL_LSB +: 6];
				state_d.psel     = i_wdata[MON_PSEL_LSB +: 4];
				state_d.sample_clock_on      = i_wdata[MON_CEN_BIT];
				state_d.mode     = i_wdata[MON_MODE_BIT];
				state_d.stby     = i_wdata[MON_STBY_BIT];
				state_d.act      = i_wdata[MON_ACT_LSB +: 2];
				state_d.threshold_hysteresis     = i_wdata[MON_THRESHOLD_HYSTERESIS_BIT];
				state_d.en       = i_wdata[MON_EN_BIT];
				state_d.busy     = 1'b1;
				state_d.sync_cnt = 2'(SYNC_CYCLES - 1);
			end
			if (hit(i_addr, OFS_REF_CTRL)) begin
				state_d.trim = i_wdata[REF_TRIM_LSB +: 11];
				state_d.bg   = i_wdata[REF_BG_BIT];
				state_d.ts   = i_wdata[REF_TS_BIT];
			end
			if (hit(i_addr, OFS_IRQ_MASK)) begin
				state_d.mask = i_wdata[2:0];
			end
		end

		// Monitor fields take effect only when the write has crossed over.
		if (state_q.busy) begin
			if (state_q.sync_cnt == 2'h0) begin
				state_d.busy   = 1'b0;
				state_d.a_lvl  = state_q.lvl;
				state_d.a_psel = state_q.psel;
				state_d.a_cen  = state_q.sample_clock_on;
				state_d.a_mode = state_q.mode;
				state_d.a_stby = state_q.stby;
				state_d.a_act  = state_q.act;
				state_d.a_threshold_hysteresis = state_q.threshold_hysteresis;
				state_d.a_en   = state_q.en;
				set[IRQ_SYNC_DONE] = 1'b1;
			end else begin
				state_d.sync_cnt = state_q.sync_cnt - 2'h1;
			end
		end

		// Sampling clock start and stop.
		unique case (state_q.clk)
			CLK_OFF: begin
				if (state_q.a_cen) begin
					state_d.clk     = CLK_START;
					state_d.clk_cnt = 4'(CLK_START_CYCLES - 1);
				end
			end
			CLK_START: begin
				if (!state_q.a_cen) begin
					state_d.clk = CLK_OFF;
				end else if (state_q.clk_cnt == 4'h0) begin
					state_d.clk = CLK_ON;
				end else begin
					state_d.clk_cnt = state_q.clk_cnt - 4'h1;
				end
			end
			CLK_ON: begin
				if (!state_q.a_cen) begin
					state_d.clk     = CLK_STOP;
					state_d.clk_cnt = 4'(CLK_STOP_CYCLES - 1);
				end
			end
			CLK_STOP: begin
				if (state_q.a_cen) begin
					state_d.clk = CLK_ON;
				end else if (state_q.clk_cnt == 4'h0) begin
					state_d.clk = CLK_OFF;
				end else begin
					state_d.clk_cnt = state_q.clk_cnt - 4'h1;
				end
			end
			default: begin
				state_d.clk = CLK_OFF;
			end
		endcase

		// Monitor outputs.
		state_d.mon_en  = eff_en;
		state_d.strobe  = state_q.a_mode & tick & (state_q.clk == CLK_ON);
		state_d.rst_req = below & (state_q.a_act == ACT_RESET);
		set[IRQ_UNDERVOLT] = below & (state_q.a_act == ACT_IRQ);
		set[IRQ_LOOP_RDY]  = i_loop_ready & ~state_q.ready_prev;

		// Reads; reserved bits stay zero.
		if (i_rd) begin
			if (hit(i_addr, OFS_MON_CTRL)) begin
				state_d.rdata[MON_LEVEL_LSB +: 6] = state_q.lvl;
				state_d.rdata[MON_PSEL_LSB +: 4]  = state_q.psel;
				state_d.rdata[MON_CEN_BIT]  = (state_q.clk == CLK_ON) |
					(state_q.clk == CLK_STOP);
				state_d.rdata[MON_MODE_BIT] = state_q.mode;
				state_d.rdata[MON_STBY_BIT] = state_q.stby;
				state_d.rdata[MON_ACT_LSB +: 2] = state_q.act;
				state_d.rdata[MON_THRESHOLD_HYSTERESIS_BIT] = state_q.threshold_hysteresis;
				state_d.rdata[MON_EN_BIT]   = state_q.en;
			end
			if (hit(i_addr, OFS_REF_CTRL)) begin
				state_d.rdata[REF_TRIM_LSB +: 11] = state_q.trim;
				state_d.rdata[REF_BG_BIT]         = state_q.bg;
				state_d.rdata[REF_TS_BIT]         = state_q.ts;
			end
			if (hit(i_addr, OFS_IRQ_STAT)) begin
				state_d.rdata[2:0] = state_q.stat;
				clr                = state_q.stat;
			end
			if (hit(i_addr, OFS_IRQ_MASK)) begin
				state_d.rdata[2:0] = state_q.mask;
			end
			if (hit(i_addr, OFS_SYNC_STAT)) begin
				state_d.rdata[0] = state_q.busy;
			end
		end

		// An event in the clearing read's cycle survives the clear.
		state_d.stat = (state_q.stat & ~clr) | set;
		state_d.irq  = |(state_d.stat & state_d.mask);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q      <= '0;
			state_q.psel <= PSEL_RST;
			state_q.mask <= MASK_RST;
			state_q.act  <= ACT_NONE;
			state_q.clk  <= CLK_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_rdata             = state_q.rdata;
	assign o_value_refresh_req = state_q.refresh;
	assign o_mon_enable        = state_q.mon_en;
	assign o_mon_level         = state_q.a_lvl;
	assign o_mon_threshold_hysteresis          = state_q.a_threshold_hysteresis;
	assign o_mon_sampling      = state_q.a_mode;
	assign o_mon_sample_strobe = state_q.strobe;
	assign o_mon_reset_req     = state_q.rst_req;
	assign o_bg_trim           = state_q.trim;
	assign o_bg_to_adc         = state_q.bg;
	assign o_temp_sensor_on    = state_q.ts;
	assign o_irq               = state_q.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	refresh_pulse_a: assert property (
		state_q.loaded && i_wr && hit(i_addr, OFS_LOOP_SYNC) && i_wdata[REFRESH_BIT]
		&& i_loop_closed |=> o_value_refresh_req ##1 !o_value_refresh_req)
		else $error("refresh request not a single pulse after the write");
	refresh_cause_a: assert property (
		o_value_refresh_req |-> $past(i_wr && i_loop_closed && i_wdata[REFRESH_BIT]))
		else $error("refresh request without a closed-loop write");
	reserved_zero_a: assert property (
		i_rd && (hit(i_addr, OFS_LOOP_SYNC) || hit(i_addr, OFS_MON_CTRL))
		|=> o_rdata[31:22] == 10'h000 && o_rdata[11:10] == 2'h0
		&& o_rdata[7] == 1'b0 && o_rdata[5] == 1'b0 && o_rdata[0] == 1'b0)
		else $error("reserved bits read non-zero");
	nv_monitor_a: assert property (
		$rose(state_q.loaded) |-> state_q.a_lvl == $past(i_nv_level)
		&& state_q.a_en == $past(i_nv_enable) && state_q.a_act == $past(i_nv_action))
		else $error("monitor fields not loaded from the user row");
	nv_trim_a: assert property (
		$rose(state_q.loaded) |-> o_bg_trim == $past(i_nv_trim))
		else $error("bandgap trim not loaded at startup");
	clk_status_a: assert property (
		i_rd && hit(i_addr, OFS_MON_CTRL)
		|=> o_rdata[MON_CEN_BIT] == $past(state_q.clk == CLK_ON || state_q.clk == CLK_STOP))
		else $error("clock-enable readback wrong");
	clk_start_a: assert property (
		state_q.clk == CLK_OFF && state_q.a_cen
		|=> (state_q.clk == CLK_START && state_q.a_cen)[*8] ##1 state_q.clk == CLK_ON)
		else $error("sampling clock did not start in time");
	strobe_mode_a: assert property (
		o_mon_sample_strobe |-> $past(state_q.a_mode && tick && state_q.clk == CLK_ON))
		else $error("sample strobe outside sampling mode");
	standby_off_a: assert property (
		i_standby && !state_q.a_stby |=> !o_mon_enable)
		else $error("monitor left on in standby");
	reset_action_a: assert property (
		below && state_q.a_act == ACT_RESET |=> o_mon_reset_req)
		else $error("under-voltage reset not requested");
	monitor_off_a: assert property (
		!state_q.a_en |=> !o_mon_enable && !o_mon_reset_req)
		else $error("disabled monitor still active");
	bg_route_a: assert property (
		state_q.loaded && i_wr && hit(i_addr, OFS_REF_CTRL) |=> o_bg_to_adc == $past(i_wdata[2]))
		else $error("bandgap routing not updated");
	sync_window_a: assert property (
		$rose(state_q.busy) |-> state_q.busy[*3] ##1 !state_q.busy)
		else $error("write synchronization time wrong");
	sync_hold_a: assert property (
		i_wr && hit(i_addr, OFS_MON_CTRL) && state_q.busy |=> $stable(state_q.lvl))
		else $error("monitor write accepted while busy");
	irq_level_a: assert property (
		o_irq == |(state_q.stat & state_q.mask))
		else $error("interrupt output disagrees with status and mask");

	refresh_c: cover property (o_value_refresh_req);
	sync_done_c: cover property ($fell(state_q.busy));
	clk_on_c: cover property (state_q.clk == CLK_ON);
	reset_req_c: cover property (o_mon_reset_req);

endmodule

// File: bench/smrr_tb.sv
/*
 * Self-checking bench for the supply monitor and reference register bank.
 * Assumes the single-cycle register port, the three-cycle write sync and the
 * sampling clock start and stop times that the designer fixed.
 */
`timescale 1ns/1ps
module tb;
	import smrr_pkg::*;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	localparam logic [5:0]  NV_LEVEL = 6'h2A;
	localparam logic [10:0] NV_TRIM  = 11'h5A5;
	logic        i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic        i_loop_closed = 1'b0, i_loop_ready = 1'b0, i_osc_1k = 1'b0;
	logic        i_standby = 1'b0, i_supply_low = 1'b0;
	logic [31:0] o_rdata, rdv;
	logic [10:0] o_bg_trim;
	logic [5:0]  o_mon_level;
	logic        o_value_refresh_req, o_mon_enable, o_mon_threshold_hysteresis, o_mon_sampling;
	logic        o_mon_sample_strobe, o_mon_reset_req, o_bg_to_adc, o_temp_sensor_on, o_irq;
	int          fails = 0, n_compared = 0, n_req = 0, n_strobe = 0, osc_cnt = 0;

	always #12.5 i_clk = ~i_clk;

	smrr_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_loop_closed(i_loop_closed),
		.i_loop_ready(i_loop_ready), .o_value_refresh_req(o_value_refresh_req),
		.i_nv_level(NV_LEVEL), .i_nv_action(ACT_IRQ), .i_nv_threshold_hysteresis(1'b1), .i_nv_enable(1'b1),
		.i_nv_trim(NV_TRIM), .i_osc_1k(i_osc_1k), .i_standby(i_standby),
		.i_supply_low(i_supply_low), .o_mon_enable(o_mon_enable), .o_mon_level(o_mon_level),
		.o_mon_threshold_hysteresis(o_mon_threshold_hysteresis), .o_mon_sampling(o_mon_sampling),
		.o_mon_sample_strobe(o_mon_sample_strobe), .o_mon_reset_req(o_mon_reset_req),
		.o_bg_trim(o_bg_trim), .o_bg_to_adc(o_bg_to_adc), .o_temp_sensor_on(o_temp_sensor_on),
		.o_irq(o_irq));

	// Slow oscillator sped up to 20 system cycles a period to keep the run short.
	always @(posedge i_clk) begin
		if (osc_cnt == 9) begin
			osc_cnt <= 0;
			i_osc_1k <= ~i_osc_1k;
		end else begin
			osc_cnt <= osc_cnt + 1;
		end
	end

	// Pulses are counted here so a stuck level shows up as an excess count.
	always @(posedge i_clk) begin
		if (o_value_refresh_req === 1'b1) n_req <= n_req + 1;
		if (o_mon_sample_strobe === 1'b1) n_strobe <= n_strobe + 1;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rdv = o_rdata;
		@(posedge i_clk);
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_startup;
		rd(OFS_MON_CTRL);
		chk(rdv, 32'h002A0016);
		rd(OFS_REF_CTRL);
		chk(rdv, 32'h05A50000);
		chk(32'(o_mon_level), 32'(NV_LEVEL));
		chk(32'({o_mon_enable, o_mon_threshold_hysteresis}), 32'h3);
		$display("startup done");
	endtask

	task automatic t_loop;
		int s;
		s = n_req;
		wr(OFS_LOOP_SYNC, 32'h00000080);
		chk(n_req - s, 0);
		i_loop_closed <= 1'b1;
		wr(OFS_LOOP_SYNC, 32'h00000080);
		tick(1);
		chk(n_req - s, 1);
		rd(OFS_LOOP_SYNC);
		chk(rdv, 32'h0);
		i_loop_ready <= 1'b1;
		tick(2);
		rd(OFS_IRQ_STAT);
		chk(rdv & 32'h1, 32'h1);
		$display("loop refresh done");
	endtask

	task automatic t_mon;
		wr(OFS_MON_CTRL, 32'h002A0000);
		rd(OFS_SYNC_STAT);
		chk(rdv, 32'h1);
		tick(4);
		wr(OFS_MON_CTRL, 32'h00150000);
		wr(OFS_MON_CTRL, 32'h00150016);
		tick(6);
		rd(OFS_MON_CTRL);
		chk(rdv, 32'h00150000);
		chk(32'({o_mon_level, o_mon_enable, o_mon_threshold_hysteresis}), 32'h54);
		wr(OFS_MON_CTRL, 32'h00150016);
		tick(6);
		chk(32'({o_mon_enable, o_mon_threshold_hysteresis}), 32'h3);
		i_standby <= 1'b1;
		tick(4);
		chk(32'(o_mon_enable), 32'h0);
		wr(OFS_MON_CTRL, 32'h00150056);
		tick(6);
		chk(32'(o_mon_enable), 32'h1);
		i_standby <= 1'b0;
		$display("monitor control done");
	endtask

	task automatic t_actions;
		for (int a = 0; a < 4; a++) begin
			wr(OFS_MON_CTRL, 32'h00150002 | (32'(a) << MON_ACT_LSB));
			tick(6);
			rd(OFS_IRQ_STAT);
			i_supply_low <= 1'b1;
			tick(6);
			chk(32'(o_mon_reset_req), 32'(a == 1));
			chk(32'(o_irq), 32'h0);
			i_supply_low <= 1'b0;
			tick(5);
			rd(OFS_IRQ_STAT);
			chk((rdv >> IRQ_UNDERVOLT) & 32'h1, 32'(a == 2));
		end
		$display("actions done");
	endtask

	task automatic t_irq;
		wr(OFS_MON_CTRL, 32'h00150016);
		tick(6);
		wr(OFS_IRQ_MASK, 32'h4);
		i_supply_low <= 1'b1;
		tick(6);
		i_supply_low <= 1'b0;
		tick(6);
		chk(32'(o_irq), 32'h1);
		rd(OFS_IRQ_STAT);
		chk(rdv & 32'h4, 32'h4);
		chk(32'(o_irq), 32'h0);
		rd(OFS_IRQ_MASK);
		chk(rdv, 32'h4);
		$display("interrupt done");
	endtask

	task automatic t_sample;
		int s;
		wr(OFS_MON_CTRL, 32'h00151302);
		rd(OFS_MON_CTRL);
		chk(rdv, 32'h00151102);
		tick(20);
		rd(OFS_MON_CTRL);
		chk(rdv, 32'h00151302);
		chk(32'(o_mon_sampling), 32'h1);
		s = n_strobe;
		tick(320);
		chk(n_strobe - s, 4);
		wr(OFS_MON_CTRL, 32'h00150002);
		tick(4);
		rd(OFS_MON_CTRL);
		chk(rdv, 32'h00150202);
		tick(14);
		rd(OFS_MON_CTRL);
		chk(rdv, 32'h00150002);
		s = n_strobe;
		tick(100);
		chk(n_strobe - s, 0);
		chk(32'(o_mon_sampling), 32'h0);
		$display("sampling done");
	endtask

	task automatic t_ref;
		wr(OFS_REF_CTRL, 32'h03C30006);
		rd(OFS_REF_CTRL);
		chk(rdv, 32'h03C30006);
		chk(32'({o_bg_trim, o_bg_to_adc, o_temp_sensor_on}), 32'h0F0F);
		wr(OFS_REF_CTRL, 32'h07FF0002);
		rd(OFS_REF_CTRL);
		chk(rdv, 32'h07FF0002);
		chk(32'({o_bg_to_adc, o_temp_sensor_on}), 32'h1);
		rd(8'h50);
		chk(rdv, 32'h0);
		$display("reference done");
	endtask

	// ------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		tick(8);
		i_rstn <= 1'b1;
		tick(3);
		t_startup();
		t_loop();
		t_mon();
		t_actions();
		t_irq();
		t_sample();
		t_ref();
		give_verdict();
	end

	// The tests need about 670 cycles; more than twenty times that marks a hang.
	initial begin
		tick(15000);
		fails++;
		give_verdict();
	end
endmodule
